// ==== logic/power_mode_controller.sv ====
// power mode controller: idle, suspend, sleep and system clock divider
`default_nettype none
module power_mode_controller
    import pmc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              idle_set,
    input  wire logic              suspend_set,
    input  wire logic              sleep_set,
    input  wire logic              irq_any,
    input  wire logic              rtc_alarm,
    input  wire logic              rtc_fail,
    input  wire logic              port_match,
    input  wire logic              cmp0_out,
    input  wire logic [1:0]        clk_src_wr,
    input  wire logic              clk_src_we,
    input  wire logic [2:0]        clk_div_wr,
    input  wire logic              clk_div_we,
    output logic                   idle_req,
    output logic                   suspend_req,
    output logic                   sleep_req,
    output var pmc_pkg::pmode_t    mode,
    output logic                   core_run,
    output logic                   periph_clk_en,
    output logic                   osc_en,
    output logic                   power_nets_on,
    output logic                   state_hold,
    output logic                   wake_pulse,
    output logic [1:0]             clk_src,
    output logic [2:0]             clk_div,
    output logic                   system_clock_net_tick
);
    import pmc_pkg::*;

    // pin-side events pass two flops; second stage only feeds logic
    logic [WAKE_W-1:0] sync1_r;
    logic [WAKE_W-1:0] sync2_r;
    logic              cmp0_prev_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_r     <= '0;
            sync2_r     <= '0;
            cmp0_prev_r <= 1'b0;
        end else begin
            sync1_r     <= {cmp0_out, port_match, rtc_fail, rtc_alarm};
            sync2_r     <= sync1_r;
            cmp0_prev_r <= sync2_r[WAKE_CMP0];
        end
    end

    logic deep_wake;
    // only a comparator rising edge counts, not its level
    assign deep_wake = sync2_r[WAKE_RTC_ALARM] | sync2_r[WAKE_RTC_FAIL]  // RULE6
                     | sync2_r[WAKE_PORT] | (sync2_r[WAKE_CMP0] & ~cmp0_prev_r);

    pmode_t     mode_r;
    pmode_t     mode_nxt;
    logic [1:0] src_r;
    logic [1:0] src_nxt;
    logic [2:0] div_r;
    logic [2:0] div_nxt;
    logic       wake_r;
    logic       wake_nxt;

    // mode sequencing; requests only taken from normal mode
    always_comb begin
        mode_nxt = mode_r;
        wake_nxt = 1'b0;
        case (mode_r)
            MODE_NORMAL: begin
                if (sleep_set) begin
                    mode_nxt = MODE_SLEEP; // RULE4
                end else if (suspend_set && (src_r == SRC_LPOSC || src_r == SRC_HFOSC)) begin
                    mode_nxt = MODE_SUSPEND; // RULE3
                end else if (idle_set) begin
                    mode_nxt = MODE_IDLE; // RULE1
                end
            end
            MODE_IDLE: begin
                if (irq_any) begin
                    mode_nxt = MODE_NORMAL; // RULE1 RULE11
                    wake_nxt = 1'b1; // RULE7
                end
            end
            MODE_SUSPEND, MODE_SLEEP: begin
                if (deep_wake) begin
                    mode_nxt = MODE_NORMAL; // RULE6 RULE11
                    wake_nxt = 1'b1; // RULE7
                end
            end
            default: mode_nxt = MODE_NORMAL;
        endcase
    end

    // clock source and divider settings; held across every mode
    always_comb begin
        src_nxt = src_r;
        div_nxt = div_r;
        if (mode_r == MODE_NORMAL && clk_src_we) begin
            src_nxt = clk_src_wr;
        end
        if (mode_r == MODE_NORMAL && clk_div_we) begin
            div_nxt = clk_div_wr; // RULE10
        end
    end

    // only reset reloads settings; a wake never touches them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_r <= MODE_NORMAL;
            src_r  <= SRC_RESET; // RULE9
            div_r  <= DIV_SEL_RESET; // RULE9
            wake_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            src_r  <= src_nxt; // RULE5 RULE7
            div_r  <= div_nxt;
            wake_r <= wake_nxt;
        end
    end

    // registered control outputs decoded from next mode
    logic core_r;
    logic pclk_r;
    logic osc_r;
    logic pwr_r;
    logic hold_r;
    logic idle_r;
    logic susp_r;
    logic slp_r;
    // request bits registered so every output leaves a flop
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            idle_r <= 1'b0;
            susp_r <= 1'b0;
            slp_r  <= 1'b0;
        end else begin
            idle_r <= (mode_nxt == MODE_IDLE); // RULE11
            susp_r <= (mode_nxt == MODE_SUSPEND);
            slp_r  <= (mode_nxt == MODE_SLEEP);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_r <= 1'b1;
            pclk_r <= 1'b1;
            osc_r  <= 1'b1;
            pwr_r  <= 1'b1;
            hold_r <= 1'b0;
        end else begin
            core_r <= (mode_nxt == MODE_NORMAL);
            pclk_r <= (mode_nxt == MODE_NORMAL) || (mode_nxt == MODE_IDLE); // RULE2 RULE3
            osc_r  <= (mode_nxt == MODE_NORMAL) || (mode_nxt == MODE_IDLE); // RULE3
            pwr_r  <= (mode_nxt != MODE_SLEEP); // RULE4
            hold_r <= (mode_nxt == MODE_SLEEP); // RULE5
        end
    end

    // divider runs only while the oscillator is on
    clk_div_if cdiv ();
    assign cdiv.sel = div_r;
    assign cdiv.run = osc_r;
    system_clock_net_divider u_div (
        .ref_clk (ref_clk),
        .reset   (reset),
        .dv      (cdiv.div)
    );

    assign mode          = mode_r;
    assign idle_req      = idle_r; // RULE11
    assign suspend_req   = susp_r;
    assign sleep_req     = slp_r;
    assign core_run      = core_r;
    assign periph_clk_en = pclk_r;
    assign osc_en        = osc_r;
    assign power_nets_on = pwr_r;
    assign state_hold    = hold_r;
    assign wake_pulse    = wake_r;
    assign clk_src       = src_r;
    assign clk_div       = div_r;
    assign system_clock_net_tick   = cdiv.tick;

    idle_enter_a: assert property (@(posedge ref_clk) disable iff (reset)
        mode_r == MODE_NORMAL && idle_set && !sleep_set && !suspend_set |=> idle_req && !core_r && pclk_r) // RULE1
        else $error("idle entry wrong");
    idle_periph_a: assert property (@(posedge ref_clk) disable iff (reset)
        idle_req |-> pclk_r && osc_r) // RULE2
        else $error("peripherals stopped in idle");
    suspend_src_a: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(suspend_req) |-> $past(src_r) == SRC_LPOSC || $past(src_r) == SRC_HFOSC) // RULE3
        else $error("suspend from external source");
    suspend_osc_a: assert property (@(posedge ref_clk) disable iff (reset)
        suspend_req |-> !osc_r && !pclk_r && !core_r) // RULE3
        else $error("suspend left clocks running");
    sleep_power_a: assert property (@(posedge ref_clk) disable iff (reset)
        mode_r == MODE_NORMAL && sleep_set |=> sleep_req && !pwr_r && hold_r) // RULE4 RULE5
        else $error("sleep entry wrong");
    deep_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
        (suspend_req || sleep_req) && deep_wake |=> mode_r == MODE_NORMAL && wake_r && core_r) // RULE6 RULE11
        else $error("deep wake missed");
    cmp_level_a: assert property (@(posedge ref_clk) disable iff (reset)
        sleep_req && sync2_r[WAKE_CMP0] && cmp0_prev_r && sync2_r[2:0] == 3'h0 |=> sleep_req) // RULE6
        else $error("comparator level woke device");
    wake_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
        wake_r |-> $stable(div_r) && $stable(src_r)) // RULE7
        else $error("wake disturbed settings");
    reset_clk_a: assert property (@(posedge ref_clk)
        $fell(reset) |-> src_r == SRC_LPOSC && div_r == 3'h3) // RULE9
        else $error("reset clock settings wrong");
    cov_idle: cover property (@(posedge ref_clk) disable iff (reset) idle_req ##[1:20] wake_r);
    cov_susp: cover property (@(posedge ref_clk) disable iff (reset) suspend_req ##[1:20] wake_r);
    cov_sleep: cover property (@(posedge ref_clk) disable iff (reset) sleep_req ##[1:20] wake_r);
endmodule
`default_nettype wire

// ==== logic/pmc_pkg.sv ====
// shared constants and types for the power mode controller
//
// How it works
// RULE1 - idle request halts core until any interrupt
// RULE2 - idle keeps peripherals clocked and running
// RULE3 - suspend needs internal oscillator; stops oscillators, peripherals
// RULE4 - sleep request shuts down most power nets
// RULE5 - sleep holds pins, ram and registers
// RULE6 - suspend/sleep wake on rtc, port, comparator
// RULE7 - wake resumes execution, never resets
// RULE8 - software disables unused analog before sleep
// RULE9 - reset runs low-power oscillator divided by eight
// RULE10 - divider gives powers of two 1..128
// RULE11 - hardware clears request bit on wake
`default_nettype none
package pmc_pkg;
    // power modes, gray coded in the order normal, idle, suspend, sleep
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_IDLE    = 2'h1,
        MODE_SUSPEND = 2'h3,
        MODE_SLEEP   = 2'h2
    } pmode_t;

    // system clock source selections
    localparam logic [1:0] SRC_LPOSC = 2'h0;
    localparam logic [1:0] SRC_HFOSC = 2'h1;
    localparam logic [1:0] SRC_EXT   = 2'h2;
    localparam logic [1:0] SRC_RTC   = 2'h3;

    localparam int          DIV_SEL_W     = 3;
    localparam int          DIV_CNT_W     = 7;
    localparam logic [2:0]  DIV_SEL_RESET = 3'h3;      // divide by 8
    localparam logic [1:0]  SRC_RESET     = SRC_LPOSC;
    localparam int          LPOSC_FREQ_MHZ = 20;

    // wake source bit positions
    localparam int WAKE_RTC_ALARM = 0;
    localparam int WAKE_RTC_FAIL  = 1;
    localparam int WAKE_PORT      = 2;
    localparam int WAKE_CMP0      = 3;
    localparam int WAKE_W         = 4;

    // terminal count for a divide setting: 2^sel - 1
    function automatic logic [DIV_CNT_W-1:0] div_limit(input logic [DIV_SEL_W-1:0] sel);
        logic [DIV_CNT_W:0] one_hot;
        one_hot = 8'h01 << sel;
        div_limit = DIV_CNT_W'(one_hot - 8'h01);
    endfunction
endpackage
`default_nettype wire

// ==== logic/clk_div_if.sv ====
// interface between the mode controller and its clock divider
`default_nettype none
interface clk_div_if;
    logic [2:0] sel;
    logic       run;
    logic       tick;
    modport ctrl (output sel, output run, input tick);
    modport div  (input sel, input run, output tick);
endinterface
`default_nettype wire

// ==== logic/system_clock_net_divider.sv ====
// power-of-two system clock enable divider
`default_nettype none
module system_clock_net_divider
    import pmc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    clk_div_if.div    dv
);
    logic [DIV_CNT_W-1:0] cnt_r;
    logic [DIV_CNT_W-1:0] cnt_nxt;
    logic                 tick_r;
    logic                 tick_nxt;

    // count to 2^sel-1 then pulse; frozen when source stopped
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (dv.run) begin
            if (cnt_r >= div_limit(dv.sel)) begin // RULE10
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end
    assign dv.tick = tick_r;

    tick_spacing_a: assert property (@(posedge ref_clk) disable iff (reset)
        tick_r && dv.run && $stable(dv.sel) && dv.sel == 3'h1
        |=> !tick_r ##1 (tick_r || !$past(dv.run) || $past(dv.sel) != 3'h1)) // RULE10
        else $error("divide by two tick spacing wrong");
endmodule
`default_nettype wire

// ==== bench/power_mode_controller_tb.sv ====
// self-checking bench for the power mode controller
`default_nettype none
module power_mode_controller_tb
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk, reset, idle_set, suspend_set, sleep_set, irq_any;
    logic       rtc_alarm, rtc_fail, port_match, cmp0_out, clk_src_we, clk_div_we;
    logic [1:0] clk_src_wr, clk_src;
    logic [2:0] clk_div_wr, clk_div;
    logic       idle_req, suspend_req, sleep_req, core_run, periph_clk_en, osc_en;
    logic       power_nets_on, state_hold, wake_pulse, system_clock_net_tick;
    pmode_t     mode;
    int         error_cnt, comparisons;

    // one row per mode entry: request, wake source, expected mode, masked levels
    typedef struct {
        logic [1:0] req;
        int         wk;
        pmode_t     md;
        logic [4:0] lvl;
        logic [4:0] msk;
    } row_t;
    row_t rows [6] = '{
        '{2'h1, 0, MODE_IDLE, 5'h08, 5'h18},
        '{2'h2, 1, MODE_SUSPEND, 5'h00, 5'h1C},
        '{2'h2, 2, MODE_SUSPEND, 5'h00, 5'h1C},
        '{2'h3, 3, MODE_SLEEP, 5'h01, 5'h13},
        '{2'h3, 4, MODE_SLEEP, 5'h01, 5'h13},
        '{2'h2, 4, MODE_SUSPEND, 5'h00, 5'h1C}};

    power_mode_controller uut (
        .ref_clk, .reset, .idle_set, .suspend_set, .sleep_set, .irq_any, .rtc_alarm, .rtc_fail,
        .port_match, .cmp0_out, .clk_src_wr, .clk_src_we, .clk_div_wr, .clk_div_we, .idle_req,
        .suspend_req, .sleep_req, .mode, .core_run, .periph_clk_en, .osc_en, .power_nets_on,
        .state_hold, .wake_pulse, .clk_src, .clk_div, .system_clock_net_tick);

    // free-running 20 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // settle 1 ns past the last edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic drive_req(input logic [1:0] r, input logic v);
        case (r)
            2'h1: idle_set <= v;
            2'h2: suspend_set <= v;
            default: sleep_set <= v;
        endcase
    endtask

    task automatic drive_wake(input int w, input logic v);
        case (w)
            0: irq_any <= v;
            1: rtc_alarm <= v;
            2: rtc_fail <= v;
            3: port_match <= v;
            default: cmp0_out <= v;
        endcase
    endtask

    task automatic request(input logic [1:0] r);
        @(posedge ref_clk) drive_req(r, 1'b1);
        @(posedge ref_clk) drive_req(r, 1'b0);
        #1;
    endtask

    task automatic wr_cfg(input logic [1:0] s, input logic [2:0] d);
        @(posedge ref_clk);
        clk_src_wr <= s;
        clk_div_wr <= d;
        clk_src_we <= 1'b1;
        clk_div_we <= 1'b1;
        @(posedge ref_clk);
        clk_src_we <= 1'b0;
        clk_div_we <= 1'b0;
        #1;
    endtask

    // bounded wait for the wake pulse; running out ends the run
    task automatic wait_wake();
        int n;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (wake_pulse !== 1'b1 && n < 12);
        chk(9'(wake_pulse), 9'h001);
        if (wake_pulse !== 1'b1)
            tally_and_finish();
    endtask

    // first pass aligns to a tick, second counts the interval
    task automatic period(input logic [8:0] exp);
        int n;
        n = 0;
        repeat (2) begin
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (system_clock_net_tick !== 1'b1 && n < 300);
        end
        chk(9'(n), exp);
    endtask

    initial begin
        {idle_set, suspend_set, sleep_set, irq_any, rtc_alarm, rtc_fail} = 6'h00;
        {port_match, cmp0_out, clk_src_we, clk_div_we} = 4'h0;
        clk_src_wr = 2'h0;
        clk_div_wr = 3'h0;
        error_cnt = 0;
        comparisons = 0;
        reset = 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        cyc(1);
        chk(9'(mode), 9'(MODE_NORMAL));
        chk(9'(clk_src), 9'(SRC_LPOSC));
        chk(9'(clk_div), 9'h003);
        period(9'h008);
        for (int s = 0; s < 8; s++) begin
            wr_cfg(2'h1, 3'(s));
            period(9'(1 << s));
        end
        // table: enter each mode, wake from each source, divider setting survives
        foreach (rows[i]) begin
            wr_cfg(2'h0, 3'(i));
            request(rows[i].req);
            cyc(3);
            chk(9'(mode), 9'(rows[i].md));
            chk(9'({idle_req, suspend_req, sleep_req}), 9'(3'h1 << (3 - rows[i].req)));
            chk(9'({core_run, periph_clk_en, osc_en, power_nets_on, state_hold} & rows[i].msk),
                9'(rows[i].lvl));
            @(posedge ref_clk) drive_wake(rows[i].wk, 1'b1);
            wait_wake();
            chk(9'(mode), 9'(MODE_NORMAL));
            chk(9'({idle_req, suspend_req, sleep_req, core_run}), 9'h001);
            chk(9'(clk_div), 9'(i));
            @(posedge ref_clk) drive_wake(rows[i].wk, 1'b0);
            cyc(5);
        end
        // suspend refused while running from an external source
        wr_cfg(2'h2, 3'h0);
        request(2'h2);
        cyc(2);
        chk(9'(mode), 9'(MODE_NORMAL));
        // comparator already high must not wake sleep; only a new rising edge
        wr_cfg(2'h1, 3'h0);
        @(posedge ref_clk) cmp0_out <= 1'b1;
        cyc(5);
        request(2'h3);
        cyc(6);
        chk(9'(mode), 9'(MODE_SLEEP));
        @(posedge ref_clk) cmp0_out <= 1'b0;
        cyc(4);
        chk(9'(mode), 9'(MODE_SLEEP));
        @(posedge ref_clk) cmp0_out <= 1'b1;
        wait_wake();
        chk(9'(clk_src), 9'(SRC_HFOSC));
        tally_and_finish();
    end
endmodule
`default_nettype wire
